// ===== phsr_regs.sv
// Our own choice: the APB register port.
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01 - receive signal loss latches a status bit until register read or reset
// RULE_02 - pll lock failure latches a lock-error bit until read or reset
// RULE_03 - missing start delimiter pair latches the false-carrier bit until read or reset
// RULE_04 - invalid symbol in packet raises receive error to mac and latches bit
// RULE_05 - halt symbol signals mac and latches halt bit until read or reset
// RULE_06 - two consecutive idles in packet latch the premature-end bit
// RULE_07 - the six receive event bits are meaningless in 10base-t mode
// RULE_08 - negotiation-complete reads one only when finished and enabled
// RULE_09 - signal-detect follows twisted-pair signal presence in 100base-tx mode
// RULE_10 - jabber bit mirrors the basic status jabber bit
// RULE_11 - remote-fault bit mirrors the basic status remote-fault bit
// RULE_12 - link bit mirrors the basic status link bit
// RULE_13 - 10base-t operations register sits at management address 18
// RULE_14 - software writes default values into reserved operations bits
// RULE_15 - auto-polarity-inhibit one leaves reversed polarity uncorrected
// RULE_16 - test-inhibit one suppresses the signal quality error test
// RULE_17 - link-loss-inhibit one forces the 10base-t link to pass
// RULE_18 - jabber-inhibit one disables 10base-t jabber checking
// RULE_19 - squelch-inhibit one bypasses 10base-t squelch qualification
// RULE_20 - remote jabber latches high, cleared by reading the operations register
module phsr_regs (
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        rst_b_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [9:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// receive path events, one-cycle or level
	input  wire logic        sig_lost_in,
	input  wire logic        lock_fail_in,
	input  wire logic        false_carrier_in,
	input  wire logic        rx_active_in,
	input  wire logic        inv_symbol_in,
	input  wire logic        halt_symbol_in,
	input  wire logic        idle_symbol_in,
	input  wire logic        symbol_valid_in,
	input  wire logic        rx_jabber_in,
	input  wire logic        pol_reversed_in,
	// status from other blocks
	input  wire logic        an_complete_in,
	input  wire logic        signal_present_in,
	input  wire logic        basic_jabber_in,
	input  wire logic        basic_rfault_in,
	input  wire logic        basic_link_in,
	// toward mac and 10base-t logic
	output logic             rx_error_out,
	output logic             sel_100_out,
	output logic             an_enable_out,
	output logic             auto_pol_en_out,
	output logic             sqe_test_en_out,
	output logic             link_force_pass_out,
	output logic             jabber_check_en_out,
	output logic             squelch_en_out
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [10:5] lh;       // latched receive events
		logic        prev_idle;
		logic        rjab;
		logic        pol_rev;
		logic [13:0] ops;
		logic [1:0]  ctrl;
		logic        rx_err;
	} phsr_state_t;

	phsr_state_t st_q;
	phsr_state_t st_d;
	logic        acc;
	logic        wr;
	logic        rd;
	logic        rd_fast;
	logic        rd_ops;
	logic        hit;
	logic [15:0] fast_view;
	logic        in_pkt;

	// ****************************************
	// bus decode
	// ****************************************
	// zero wait states, so the access phase always finishes in one cycle
	assign acc     = psel_in & penable_in;
	assign wr      = acc & pwrite_in;
	assign rd      = acc & ~pwrite_in;
	assign hit     = (paddr_in == phsr_pkg::FAST_RX_ADDR) | (paddr_in == phsr_pkg::TEN_OPS_ADDR)
		| (paddr_in == phsr_pkg::CTRL_ADDR);
	assign rd_fast = rd & (paddr_in == phsr_pkg::FAST_RX_ADDR);
	assign rd_ops  = rd & (paddr_in == phsr_pkg::TEN_OPS_ADDR);     // [RULE_13]
	assign in_pkt  = rx_active_in & symbol_valid_in;

	// live view of the receive status word
	always_comb begin
		fast_view = 16'h0000;
		fast_view[10:5] = st_q.lh;
		// zero unless enabled and finished
		fast_view[phsr_pkg::AN_DONE_BIT] = an_complete_in & st_q.ctrl[phsr_pkg::CTRL_AN_BIT]; // [RULE_08]
		fast_view[phsr_pkg::SIG_DET_BIT] = signal_present_in & st_q.ctrl[phsr_pkg::CTRL_100_BIT]; // [RULE_09]
		fast_view[phsr_pkg::JABBER_BIT]  = basic_jabber_in;   // [RULE_10]
		fast_view[phsr_pkg::RFAULT_BIT]  = basic_rfault_in;   // [RULE_11]
		fast_view[phsr_pkg::LINK_BIT]    = basic_link_in;     // [RULE_12]
	end

	// ****************************************
	// next state
	// ****************************************
	// events in the read cycle are kept: the set wins over the read clear
	always_comb begin
		st_d = st_q;
		st_d.rx_err = in_pkt & inv_symbol_in;               // [RULE_04]
		if (rd_fast) begin
			st_d.lh = 6'h00;
		end
		if (rd_ops) begin
			st_d.rjab    = 1'b0;                             // [RULE_20]
			st_d.pol_rev = 1'b0;
		end
		st_d.prev_idle = in_pkt & idle_symbol_in;
		// the six receive events are only sampled in 100base mode; in 10base-t the bits carry nothing
		if (st_q.ctrl[phsr_pkg::CTRL_100_BIT]) begin         // [RULE_07]
			if (sig_lost_in) begin
				st_d.lh[phsr_pkg::SIG_LOST_BIT] = 1'b1;      // [RULE_01]
			end
			if (lock_fail_in) begin
				st_d.lh[phsr_pkg::LOCK_ERR_BIT] = 1'b1;      // [RULE_02]
			end
			if (false_carrier_in) begin
				st_d.lh[phsr_pkg::FALSE_CAR_BIT] = 1'b1;     // [RULE_03]
			end
			if (in_pkt & inv_symbol_in) begin
				st_d.lh[phsr_pkg::INV_SYM_BIT] = 1'b1;       // [RULE_04]
			end
			if (in_pkt & halt_symbol_in) begin
				st_d.lh[phsr_pkg::HALT_BIT] = 1'b1;          // [RULE_05]
			end
			if (in_pkt & idle_symbol_in & st_q.prev_idle) begin
				st_d.lh[phsr_pkg::PREM_END_BIT] = 1'b1;      // [RULE_06]
			end
		end
		if (rx_jabber_in) begin
			st_d.rjab = 1'b1;                                // [RULE_20]
		end
		if (pol_reversed_in) begin
			st_d.pol_rev = 1'b1;
		end
		// reserved bits store whatever software writes; software keeps defaults
		if (wr & (paddr_in == phsr_pkg::TEN_OPS_ADDR)) begin
			st_d.ops = pwdata_in[13:0] & phsr_pkg::OPS_RW_MASK;  // [RULE_14]
		end
		if (wr & (paddr_in == phsr_pkg::CTRL_ADDR)) begin
			st_d.ctrl = pwdata_in[1:0];
		end
		// halt also flags the mac, but only where 100base symbols have meaning
		if (st_q.ctrl[phsr_pkg::CTRL_100_BIT] & halt_symbol_in & in_pkt) begin
			st_d.rx_err = 1'b1;                              // [RULE_05]
		end
		if (~rst_b_in) begin
			st_d = '0;
			st_d.ops  = phsr_pkg::OPS_RESET;
			st_d.ctrl = phsr_pkg::CTRL_RESET;
		end
	end

	// state register
	always_ff @(posedge clock_in) begin
		st_q <= st_d;
	end

	// ****************************************
	// read mux and outputs
	// ****************************************
	always_comb begin
		prdata_out = phsr_pkg::ZERO_WORD;
		if (rd && paddr_in == phsr_pkg::FAST_RX_ADDR) begin
			prdata_out[15:0] = fast_view;
		end else if (rd && paddr_in == phsr_pkg::TEN_OPS_ADDR) begin
			prdata_out[phsr_pkg::RJAB_BIT]    = st_q.rjab;
			prdata_out[phsr_pkg::POL_REV_BIT] = st_q.pol_rev;
			prdata_out[13:0]                  = st_q.ops;
		end else if (rd && paddr_in == phsr_pkg::CTRL_ADDR) begin
			prdata_out[1:0] = st_q.ctrl;
		end
	end

	assign pready_out          = 1'b1;
	assign pslverr_out         = acc & ~hit;    // unmapped address answers with an error
	assign rx_error_out        = st_q.rx_err;   // [RULE_04]
	assign sel_100_out         = st_q.ctrl[phsr_pkg::CTRL_100_BIT];
	assign an_enable_out       = st_q.ctrl[phsr_pkg::CTRL_AN_BIT];
	assign auto_pol_en_out     = ~st_q.ops[phsr_pkg::OPS_POL_INH];   // [RULE_15]
	assign sqe_test_en_out     = ~st_q.ops[phsr_pkg::OPS_SQE_INH];   // [RULE_16]
	assign link_force_pass_out = st_q.ops[phsr_pkg::OPS_LINK_INH];   // [RULE_17]
	assign jabber_check_en_out = ~st_q.ops[phsr_pkg::OPS_JAB_INH];   // [RULE_18]
	assign squelch_en_out      = ~st_q.ops[phsr_pkg::OPS_SQL_INH];   // [RULE_19]
endmodule

// ===== phsr_pkg.sv
package phsr_pkg;
	// ****************************************
	// register indices and byte addresses
	// ****************************************
	localparam logic [7:0] TEN_OPS_IDX   = 8'h12;          // management address 18
	localparam logic [7:0] FAST_RX_IDX   = 8'h11;          // management address 17
	localparam logic [9:0] TEN_OPS_ADDR  = 10'h048;        // four times the index
	localparam logic [9:0] FAST_RX_ADDR  = 10'h044;
	localparam logic [9:0] CTRL_ADDR     = 10'h080;        // mode and auto-neg enable
	// ****************************************
	// field positions
	// ****************************************
	localparam int SIG_LOST_BIT  = 10;
	localparam int LOCK_ERR_BIT  = 9;
	localparam int FALSE_CAR_BIT = 8;
	localparam int INV_SYM_BIT   = 7;
	localparam int HALT_BIT      = 6;
	localparam int PREM_END_BIT  = 5;
	localparam int AN_DONE_BIT   = 4;
	localparam int SIG_DET_BIT   = 3;
	localparam int JABBER_BIT    = 2;
	localparam int RFAULT_BIT    = 1;
	localparam int LINK_BIT      = 0;
	localparam int RJAB_BIT      = 15;
	localparam int POL_REV_BIT   = 14;
	localparam int CTRL_100_BIT  = 0;
	localparam int CTRL_AN_BIT   = 1;
	// ****************************************
	// control fields and reset values
	// ****************************************
	localparam logic [13:0] OPS_RW_MASK  = 14'h3FFF;       // bits 13:0 are writable
	localparam logic [13:0] OPS_RESET    = 14'h0010;       // reserved bit 4 defaults to one
	localparam logic [1:0]  CTRL_RESET   = 2'h3;           // 100Base, auto-neg enabled
	localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
	localparam int          OPS_JAB_INH  = 5;
	localparam int          OPS_POL_INH  = 3;
	localparam int          OPS_SQE_INH  = 2;
	localparam int          OPS_LINK_INH = 1;
	localparam int          OPS_SQL_INH  = 0;
endpackage

// ===== phsr_regs_props.sv
`timescale 1ns/10ps
module phsr_regs_props (
	// watched ports
	input wire logic        clock_in, rst_b_in, psel_in, penable_in, pwrite_in,
	input wire logic [9:0]  paddr_in,
	input wire logic [31:0] pwdata_in, prdata_out,
	input wire logic        rx_active_in, symbol_valid_in, inv_symbol_in, halt_symbol_in,
	input wire logic        idle_symbol_in, sig_lost_in, an_complete_in, signal_present_in,
	input wire logic        basic_jabber_in, basic_rfault_in, basic_link_in, rx_error_out,
	input wire logic        sel_100_out, an_enable_out, auto_pol_en_out, sqe_test_en_out,
	input wire logic        link_force_pass_out, jabber_check_en_out, squelch_en_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	// helper terms; rst_b_in folded in so an event swallowed by reset is not expected
	logic       in_pkt, rd_fast, wr_ops, lost100, idle100;
	logic [4:0] ctl_exp;
	assign in_pkt  = rx_active_in & symbol_valid_in;
	assign rd_fast = psel_in & penable_in & !pwrite_in & (paddr_in == phsr_pkg::FAST_RX_ADDR);
	assign wr_ops  = psel_in & penable_in & pwrite_in & (paddr_in == phsr_pkg::TEN_OPS_ADDR);
	assign lost100 = sig_lost_in & sel_100_out & rst_b_in;
	assign idle100 = in_pkt & idle_symbol_in & sel_100_out & rst_b_in;
	assign ctl_exp = {pwdata_in[5], pwdata_in[3:0]} ^ 5'h1D; // enables are inverted inhibits
	a_inv_rxerr: assert property (in_pkt && inv_symbol_in |=> rx_error_out)
		else $error("no receive error after invalid symbol");
	a_halt_rxerr: assert property (in_pkt && halt_symbol_in && sel_100_out |=> rx_error_out)
		else $error("no receive error after halt symbol");
	a_lost_latch: assert property (rd_fast && $past(lost100, 2) |-> prdata_out[10])
		else $error("signal lost bit not latched");
	a_idle_pair: assert property (rd_fast && $past(idle100) && $past(idle100, 2) |-> prdata_out[5])
		else $error("premature end bit not latched");
	a_an_done: assert property (rd_fast |-> prdata_out[4] == (an_complete_in && an_enable_out))
		else $error("negotiation complete bit wrong");
	a_sig_det: assert property (rd_fast |-> prdata_out[3] == (signal_present_in && sel_100_out))
		else $error("signal detect bit wrong");
	a_mirror_bits: assert property (rd_fast |-> prdata_out[2:0] ==
		{basic_jabber_in, basic_rfault_in, basic_link_in})
		else $error("mirrored status bits wrong");
	a_ops_ctrl: assert property (wr_ops |=> {jabber_check_en_out, auto_pol_en_out, sqe_test_en_out,
		link_force_pass_out, squelch_en_out} == $past(ctl_exp))
		else $error("10base-t controls do not follow write");
endmodule
bind phsr_regs phsr_regs_props u_props (.*);

// ===== phsr_rx_model.sv
`timescale 1ns/10ps
module phsr_rx_model (
	// clock and command
	input  wire logic       clock_in,
	input  wire logic       go_in,
	input  wire logic [1:0] sym_in,
	// symbol stream: flags are idle, halt, invalid
	output logic            rx_active_out,
	output logic            symbol_valid_out,
	output logic [2:0]      flags_out
);
	initial {rx_active_out, symbol_valid_out, flags_out} = 5'h00;
	// one symbol per command cycle; stream stands idle between frames
	always @(posedge clock_in) begin
		rx_active_out    <= go_in;
		symbol_valid_out <= go_in;
		flags_out        <= {go_in && sym_in == 2'h3, go_in && sym_in == 2'h2, go_in && sym_in == 2'h1};
	end
endmodule

// ===== tb_phsr_regs.sv
`timescale 1ns/10ps
module tb_phsr_regs;
	logic        clock_in = 1'b0, rst_b_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
	logic        pwrite_in = 1'b0, go = 1'b0, e;
	logic [9:0]  paddr_in = 10'h000;
	logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, rd;
	logic [1:0]  sym = 2'h0;
	logic [4:0]  ev = 5'h00, st = 5'h1D;
	logic        pready_out, pslverr_out, rx_error_out, sel_100_out, an_enable_out;
	logic        auto_pol_en_out, sqe_test_en_out, link_force_pass_out, jabber_check_en_out, squelch_en_out;
	wire logic   rx_active_in, symbol_valid_in, inv_symbol_in, halt_symbol_in, idle_symbol_in;
	wire logic   sig_lost_in, lock_fail_in, false_carrier_in, rx_jabber_in, pol_reversed_in;
	wire logic   an_complete_in, signal_present_in, basic_jabber_in, basic_rfault_in, basic_link_in;
	int          miscompares = 0, n_tests = 0;
	assign {rx_jabber_in, pol_reversed_in, sig_lost_in, lock_fail_in, false_carrier_in} = ev;
	assign {an_complete_in, signal_present_in, basic_jabber_in, basic_rfault_in, basic_link_in} = st;
	phsr_regs dut_u (.*);
	phsr_rx_model rx_u (.clock_in(clock_in), .go_in(go), .sym_in(sym), .rx_active_out(rx_active_in),
		.symbol_valid_out(symbol_valid_in), .flags_out({idle_symbol_in, halt_symbol_in, inv_symbol_in}));
	always #5 clock_in = ~clock_in;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// apb transfer: held until pready is sampled high, data taken at that edge
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge clock_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clock_in);
		penable_in <= 1'b1;
		@(posedge clock_in);
		while (pready_out !== 1'b1) @(posedge clock_in);
		rd = prdata_out;
		e = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic rdchk(input string nm, input logic [9:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, rd, exp);
	endtask
	task automatic pulse(input logic [4:0] m);
		@(posedge clock_in);
		ev <= m;
		@(posedge clock_in);
		ev <= 5'h00;
	endtask
	task automatic frame(input logic [1:0] s, input int n);
		@(posedge clock_in);
		go <= 1'b1;
		sym <= s;
		repeat (n) @(posedge clock_in);
		go <= 1'b0;
	endtask
	task automatic ctl_chk(input logic [31:0] exp);
		@(negedge clock_in);
		chk("ctl", {27'h0, jabber_check_en_out, auto_pol_en_out, sqe_test_en_out,
			link_force_pass_out, squelch_en_out}, exp);
	endtask
	task automatic end_sim;
		$display("checks %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (20) @(posedge clock_in);
		rst_b_in <= 1'b1;
		rdchk("ops", phsr_pkg::TEN_OPS_ADDR, 32'h0000_0010);
		rdchk("sts", phsr_pkg::FAST_RX_ADDR, 32'h0000_001D);
		for (int i = 0; i < 3; i++) begin
			pulse(5'h01 << i);
			rdchk("ev", phsr_pkg::FAST_RX_ADDR,
				32'h0000_001D | (32'h0000_0100 << i));
			rdchk("evclr", phsr_pkg::FAST_RX_ADDR, 32'h0000_001D);
		end
		// two idles in a row must count as a premature end
		for (int i = 1; i < 5; i++) begin
			frame(2'(i), (i == 3) ? 2 : 1);
			rdchk("sym", phsr_pkg::FAST_RX_ADDR,
				32'h0000_001D | ((32'h0000_0100 >> i) & 32'h0000_00E0));
		end
		pulse(5'h18);
		rdchk("opslh", phsr_pkg::TEN_OPS_ADDR, 32'h0000_C010);
		rdchk("opsclr", phsr_pkg::TEN_OPS_ADDR, 32'h0000_0010);
		apb(1'b1, phsr_pkg::TEN_OPS_ADDR, 32'h0000_003F);
		ctl_chk(32'h0000_0002);
		rdchk("opsrw", phsr_pkg::TEN_OPS_ADDR, 32'h0000_003F);
		apb(1'b1, phsr_pkg::TEN_OPS_ADDR, 32'h0000_0010);
		ctl_chk(32'h0000_001D);
		// 10base-t mode with negotiation off: event bits stay clear
		apb(1'b1, phsr_pkg::CTRL_ADDR, 32'h0000_0000);
		@(negedge clock_in);
		chk("mode", {30'h0, an_enable_out, sel_100_out}, 32'h0000_0000);
		st <= 5'h1A;
		pulse(5'h07);
		frame(2'h1, 1);
		rdchk("ten", phsr_pkg::FAST_RX_ADDR, 32'h0000_0002);
		rdchk("unmap", 10'h3FC, 32'h0000_0000);
		chk("slverr", {31'h0, e}, 32'h0000_0001);
		end_sim;
	end
	// watchdog: the sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clock_in);
		miscompares++;
		end_sim;
	end
endmodule
